/* include/lcd_dec_consts.svh */
// Register offsets, field positions, reset values and timing figures of the decoder
`ifndef LCD_DEC_CONSTS_SVH
`define LCD_DEC_CONSTS_SVH
// =====================================================
// Register offsets (byte addresses)
`define OFS_INSTR 8'h00
`define OFS_STATUS 8'h04
`define OFS_MODE 8'h08
`define OFS_ACCESS 8'h0c
`define OFS_REFUSED 8'h10
// =====================================================
// Field positions
`define ST_BUSY_BIT 7
`define MD_ENTRY_INC 0
`define MD_ENTRY_SHIFT 1
`define MD_DISP_ON 2
`define MD_CURSOR_ON 3
`define MD_BLINK_ON 4
`define MD_BUS_8BIT 5
`define MD_EXT_GROUP 6
`define MD_SCROLL_SEL 7
`define MD_SLEEP_EXIT 8
`define MD_GRAPHIC_ON 9
`define MD_STANDBY 10
`define MD_REV_LO 12
`define MD_REV_HI 15
`define MD_SHIFT_LO 16
`define MD_SHIFT_HI 23
// =====================================================
// Reset values and codes
`define AC_RST 7'h00
`define SHIFT_RST 8'h00
`define REV_RST 4'h0
`define SPACE_CODE 8'h20
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10
// =====================================================
// Timing
`define CLK_PERIOD_NS 10
`define T_CLEAR_NS 1600000
`define T_EXEC_NS 72000
`endif

/* include/lcd_dec_pkg.sv */
// Types shared by the instruction decoder files
package lcd_dec_pkg;
	typedef enum logic {
		GRP_BASIC = 1'b0,
		GRP_EXT = 1'b1
	} group_t;
	typedef enum logic [1:0] {
		TMR_IDLE = 2'b00,
		TMR_RUN = 2'b01
	} tmr_state_t;
endpackage : lcd_dec_pkg

/* verilog/exec_timer.sv */
// Execution timer that holds busy for the length of one instruction
`include "lcd_dec_consts.svh"
module exec_timer #(
	parameter int LONG_CYC = 160000,
	parameter int SHORT_CYC = 7200
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic start,
	input wire logic long_sel,
	output logic busy
);
	import lcd_dec_pkg::*;
	localparam int CW = $clog2(LONG_CYC + 1);

	generate
		if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC) begin : g_bad
			$error("exec_timer: counts must be >= 1 and long >= short");
		end
	endgenerate

	tmr_state_t state_r;
	logic [CW-1:0] cnt_r;
	wire cnt_zero = (cnt_r == '0);
	wire [CW-1:0] load_val = long_sel ? CW'(LONG_CYC - 1) : CW'(SHORT_CYC - 1);

	assign busy = (state_r == TMR_RUN);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= TMR_IDLE;
			cnt_r <= '0;
		end else begin
			case (state_r)
				TMR_IDLE: begin
					if (start) begin
						state_r <= TMR_RUN;
						cnt_r <= load_val;
					end
				end
				TMR_RUN: begin
					if (cnt_zero) begin
						state_r <= TMR_IDLE;
					end else begin
						cnt_r <= cnt_r - 1'b1;
					end
				end
				default: begin
					state_r <= TMR_IDLE;
				end
			endcase
		end
	end
endmodule : exec_timer

/* verilog/axil_port.sv */
// AXI4-Lite slave front end: one write and one read under way at a time
`include "lcd_dec_consts.svh"
module axil_port #(
	parameter int ADDR_W = 8
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic wr_en,
	output logic [ADDR_W-1:0] wr_addr,
	output logic [31:0] wr_data,
	input wire logic wr_ok,
	output logic [ADDR_W-1:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_ok
);
	generate
		if (ADDR_W < 5) begin : g_bad
			$error("axil_port: address too narrow for the register map");
		end
	endgenerate

	logic aw_have_r, w_have_r;
	logic [ADDR_W-1:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic w_lane0_r;

	assign awready = !aw_have_r && !bvalid;
	assign wready = !w_have_r && !bvalid;
	assign arready = !rvalid;
	// Both halves held and the previous response gone: perform the write
	wire do_write = aw_have_r && w_have_r && !bvalid;
	assign wr_en = do_write && w_lane0_r;
	assign wr_addr = aw_addr_r;
	assign wr_data = w_data_r;
	assign rd_addr = araddr;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			aw_have_r <= 1'b0;
			aw_addr_r <= '0;
		end else if (awvalid && awready) begin
			aw_have_r <= 1'b1;
			aw_addr_r <= awaddr;
		end else if (do_write) begin
			aw_have_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			w_have_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_lane0_r <= 1'b0;
		end else if (wvalid && wready) begin
			w_have_r <= 1'b1;
			w_data_r <= wdata;
			w_lane0_r <= wstrb[0];
		end else if (do_write) begin
			w_have_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bvalid <= 1'b0;
			bresp <= `AXI_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp <= wr_ok ? `AXI_OKAY : `AXI_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `AXI_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata <= rd_ok ? rd_data : 32'h0000_0000;
			rresp <= rd_ok ? `AXI_OKAY : `AXI_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end
endmodule : axil_port

/* verilog/lcd_instr_decoder.sv */
// Basic and extended instruction decoder of a character LCD controller
// Functional notes
// - Group flag stays latched until rewritten
// - Reset entry mode: increment, no shift
// - Reset display, cursor, blink all off
// - Reset: no cursor or display shift pending
// - Reset: 8-bit bus, basic group
// - Reset scroll-or-RAM select is zero
// - Reverse select zero; command toggles chosen line
// - Clear fills spaces, counter zero, increment
// - Home zeroes counter, keeps text RAM
// - Direction bit steps counter up or down
// - Shift bit shifts display each access
// - Display bit turns display on or off
// - Cursor bit shows or hides cursor
// - Blink bit blinks character at cursor
// - Shift command moves cursor or display
// - Width bit one selects 8-bit bus
// - Width bit zero selects 4-bit bus
// - Group bit picks extended or basic decoding
`include "lcd_dec_consts.svh"
module lcd_instr_decoder #(
	parameter int CLEAR_CYC = (`T_CLEAR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
	parameter int EXEC_CYC = (`T_EXEC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic busy_indicator,
	output logic [6:0] address_counter,
	output lcd_dec_pkg::group_t extended_group_select,
	output logic bus_width_select,
	output logic display_on,
	output logic cursor_on,
	output logic blink_on,
	output logic entry_inc,
	output logic entry_shift,
	output logic scroll_or_ram_select,
	output logic sleep_exit,
	output logic graphic_on,
	output logic standby,
	output logic [3:0] reverse_lines,
	output logic [7:0] shift_pos,
	output logic clear_fill,
	output logic [7:0] fill_code
);
	import lcd_dec_pkg::*;

	// The clear check below watches busy for eight cycles, the second to the ninth after the command
	generate
		if (EXEC_CYC < 1 || CLEAR_CYC < 9) begin : g_bad
			$error("lcd_instr_decoder: clear must last 9 cycles or more, instructions 1");
		end
	endgenerate

	// =====================================================
	// Bus front end
	logic wr_en;
	logic [7:0] wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data;
	logic wr_ok, rd_ok;

	axil_port #(.ADDR_W(8)) u_port (
		.clk_sys(clk_sys), .rst_n(rst_n),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .wr_ok(wr_ok),
		.rd_addr(rd_addr), .rd_data(rd_data), .rd_ok(rd_ok)
	);

	// =====================================================
	// Decode
	logic busy;
	group_t group_r;
	logic [6:0] ac_r;
	logic [7:0] shift_r;
	logic [3:0] rev_r;
	logic inc_r, shf_r, dsp_r, cur_r, blk_r, w8_r, sr_r, awake_r, gfx_r, stby_r;
	logic refused_r;
	logic [7:0] last_code_r;

	wire [7:0] code = wr_data[7:0];
	wire instr_wr = wr_en && (wr_addr == `OFS_INSTR);
	wire access_wr = wr_en && (wr_addr == `OFS_ACCESS);
	wire refused_wr = wr_en && (wr_addr == `OFS_REFUSED);
	wire take = instr_wr && !busy;
	wire access_take = access_wr && !busy;
	wire take_b = take && (group_r == GRP_BASIC);
	wire take_e = take && (group_r == GRP_EXT);
	// Opcode classes, told apart by the position of the leading one
	wire op_b0 = (code == 8'h01);
	wire op_b1 = (code[7:1] == 7'h01);
	wire op_b2 = (code[7:2] == 6'h01);
	wire op_b3 = (code[7:3] == 5'h01);
	wire op_b4 = (code[7:4] == 4'h1);
	wire op_b5 = (code[7:5] == 3'h1);
	wire op_b6 = (code[7:6] == 2'h1);
	wire op_b7 = code[7];
	wire do_clear = take_b && op_b0;
	wire do_home = take_b && op_b1;
	wire do_cshift = take_b && op_b4;
	wire [6:0] ac_up = ac_r + 7'h01;
	wire [6:0] ac_dn = ac_r - 7'h01;
	wire [7:0] sh_left = shift_r + 8'h01;
	wire [7:0] sh_right = shift_r - 8'h01;

	assign wr_ok = (wr_addr == `OFS_INSTR) || (wr_addr == `OFS_ACCESS)
		|| (wr_addr == `OFS_REFUSED) || (wr_addr == `OFS_STATUS) || (wr_addr == `OFS_MODE);
	// Same map on the read side; anything else answers with an error
	wire wr_ok_rd = (rd_addr == `OFS_INSTR) || (rd_addr == `OFS_ACCESS)
		|| (rd_addr == `OFS_REFUSED) || (rd_addr == `OFS_STATUS) || (rd_addr == `OFS_MODE);
	assign rd_ok = wr_ok_rd;

	// =====================================================
	// Next values
	wire [6:0] ac_nxt =
		(do_clear || do_home) ? `AC_RST :
		(do_cshift && !code[3]) ? (code[2] ? ac_up : ac_dn) :
		((take_b && (op_b6 || op_b7)) || (take_e && op_b6)) ? {1'b0, code[5:0]} :
		access_take ? (inc_r ? ac_up : ac_dn) :
		ac_r;
	wire [7:0] shift_nxt =
		(do_clear || do_home) ? `SHIFT_RST :
		(do_cshift && code[3]) ? (code[2] ? sh_right : sh_left) :
		(access_take && shf_r) ? (inc_r ? sh_left : sh_right) :
		shift_r;
	wire inc_nxt = do_clear ? 1'b1 : (take_b && op_b2) ? code[1] : inc_r;
	wire shf_nxt = (take_b && op_b2) ? code[0] : shf_r;
	wire dsp_nxt = (take_b && op_b3) ? code[2] : dsp_r;
	wire cur_nxt = (take_b && op_b3) ? code[1] : cur_r;
	wire blk_nxt = (take_b && op_b3) ? code[0] : blk_r;
	wire w8_nxt = (take && op_b5) ? code[4] : w8_r;
	wire grp_is_ext = (take && op_b5) ? code[2] : (group_r == GRP_EXT);
	wire gfx_nxt = (take_e && op_b5) ? code[1] : gfx_r;
	wire sr_nxt = (take_e && op_b1) ? code[0] : sr_r;
	wire [3:0] rev_nxt = (take_e && op_b2) ? (rev_r ^ (4'h1 << code[1:0])) : rev_r;
	wire awake_nxt = (take_e && op_b3) ? code[2] : awake_r;
	wire stby_nxt = take ? (take_e && op_b0) : stby_r;
	// A refusal on the same edge as a software clear keeps the flag set
	wire refused_nxt = ((instr_wr || access_wr) && busy) ? 1'b1 :
		(refused_wr && wr_data[0]) ? 1'b0 : refused_r;

	// =====================================================
	// State registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ac_r <= `AC_RST;
			shift_r <= `SHIFT_RST;
			inc_r <= 1'b1;
			shf_r <= 1'b0;
			{dsp_r, cur_r, blk_r} <= 3'h0;
			w8_r <= 1'b1;
			group_r <= GRP_BASIC;
			sr_r <= 1'b0;
			rev_r <= `REV_RST;
			awake_r <= 1'b1;
			gfx_r <= 1'b0;
			stby_r <= 1'b0;
			refused_r <= 1'b0;
			last_code_r <= 8'h00;
			clear_fill <= 1'b0;
		end else begin
			ac_r <= ac_nxt;
			shift_r <= shift_nxt;
			inc_r <= inc_nxt;
			shf_r <= shf_nxt;
			{dsp_r, cur_r, blk_r} <= {dsp_nxt, cur_nxt, blk_nxt};
			w8_r <= w8_nxt;
			group_r <= grp_is_ext ? GRP_EXT : GRP_BASIC;
			sr_r <= sr_nxt;
			rev_r <= rev_nxt;
			awake_r <= awake_nxt;
			gfx_r <= gfx_nxt;
			stby_r <= stby_nxt;
			refused_r <= refused_nxt;
			last_code_r <= take ? code : last_code_r;
			clear_fill <= do_clear;
		end
	end

	// Clear runs the long count, every other taken write the short one
	exec_timer #(.LONG_CYC(CLEAR_CYC), .SHORT_CYC(EXEC_CYC)) u_timer (
		.clk_sys(clk_sys), .rst_n(rst_n),
		.start(take || access_take), .long_sel(do_clear), .busy(busy)
	);

	// =====================================================
	// Outputs and read data
	assign busy_indicator = busy;
	assign address_counter = ac_r;
	assign extended_group_select = group_r;
	assign bus_width_select = w8_r;
	assign {display_on, cursor_on, blink_on} = {dsp_r, cur_r, blk_r};
	assign {entry_inc, entry_shift} = {inc_r, shf_r};
	assign scroll_or_ram_select = sr_r;
	assign sleep_exit = awake_r;
	assign graphic_on = gfx_r;
	assign standby = stby_r;
	assign reverse_lines = rev_r;
	assign shift_pos = shift_r;
	assign fill_code = `SPACE_CODE;

	wire [31:0] mode_word = {8'h00, shift_r, rev_r, 1'b0, stby_r, gfx_r, awake_r, sr_r,
		group_r == GRP_EXT, w8_r, blk_r, cur_r, dsp_r, shf_r, inc_r};
	wire [31:0] status_word = {24'h0, busy, ac_r};
	assign rd_data = (rd_addr == `OFS_STATUS) ? status_word :
		(rd_addr == `OFS_MODE) ? mode_word :
		(rd_addr == `OFS_REFUSED) ? {31'h0, refused_r} :
		(rd_addr == `OFS_INSTR) ? {24'h0, last_code_r} : 32'h0000_0000;

	// =====================================================
	// Assertions
	logic first_r;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) first_r <= 1'b1;
		else first_r <= 1'b0;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	reset_state_a: assert property (first_r |-> inc_r && !shf_r && !dsp_r && !cur_r && !blk_r
		&& w8_r && group_r == GRP_BASIC && !sr_r && rev_r == 4'h0 && awake_r && !gfx_r)
		else $error("reset defaults wrong");
	clear_cmd_a: assert property (do_clear |=> ac_r == 7'h00 && inc_r && clear_fill
		##1 busy[*8]) else $error("clear did not take effect");
	home_cmd_a: assert property (do_home |=> ac_r == 7'h00 && !clear_fill && $stable(inc_r))
		else $error("home wrong");
	access_step_a: assert property (access_take |=> ac_r == (inc_r ? $past(ac_up) :
		$past(ac_dn))) else $error("access step wrong");
	entry_shift_a: assert property (access_take && !shf_r |=> $stable(shift_r))
		else $error("display shifted without shift bit");
	disp_ctrl_a: assert property (take_b && op_b3 |=> {dsp_r, cur_r, blk_r} ==
		$past(code[2:0])) else $error("display control wrong");
	cursor_shift_a: assert property (do_cshift && code[3] |=> $stable(ac_r))
		else $error("display shift moved counter");
	func_set_a: assert property (take && op_b5 |=> w8_r == $past(code[4])
		&& group_r == group_t'($past(code[2]))) else $error("function set wrong");
	group_hold_a: assert property (!(take && op_b5) |=> $stable(group_r))
		else $error("group changed without function set");
	busy_refuse_a: assert property (instr_wr && busy |=> $stable(ac_r) && refused_r)
		else $error("instruction accepted while busy");
	reverse_tgl_a: assert property (take_e && op_b2 |=> rev_r != $past(rev_r))
		else $error("reverse did not toggle");
	entry_mode_a: assert property (take_b && op_b2 |=> inc_r == $past(code[1])
		&& shf_r == $past(code[0])) else $error("entry mode wrong");
	shift_step_a: assert property (access_take && shf_r |=> shift_r ==
		($past(inc_r) ? $past(sh_left) : $past(sh_right))) else $error("display shift wrong");
	cursor_move_a: assert property (do_cshift && !code[3] |=> ac_r ==
		($past(code[2]) ? $past(ac_up) : $past(ac_dn))) else $error("cursor move wrong");
	sleep_ctrl_a: assert property (take_e && op_b3 |=> awake_r == $past(code[2]))
		else $error("sleep control wrong");
	graphic_ctrl_a: assert property (take_e && op_b5 |=> gfx_r == $past(code[1]))
		else $error("graphic control wrong");
	busy_start_a: assert property (take || access_take |=> busy)
		else $error("busy did not rise");
	refuse_hold_a: assert property (refused_r && !refused_wr |=> refused_r)
		else $error("refused flag lost");
	clear_pulse_a: assert property (clear_fill |=> !clear_fill)
		else $error("fill pulse too long");

	// Cycles of busy since it last rose, to bound its length
	logic [31:0] busy_len_r;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			busy_len_r <= 32'h0000_0000;
		end else if (busy) begin
			busy_len_r <= busy_len_r + 32'h0000_0001;
		end else begin
			busy_len_r <= 32'h0000_0000;
		end
	end
	busy_len_a: assert property (busy_len_r <= 32'(CLEAR_CYC))
		else $error("busy lasted too long");

	clear_seen_c: cover property (do_clear ##1 busy [*3]);
	refuse_seen_c: cover property (instr_wr && busy);
	ext_seen_c: cover property (take_e && op_b2);
	access_seen_c: cover property (access_take && shf_r);
	group_seen_c: cover property (take && op_b5 && code[2]);
endmodule : lcd_instr_decoder

/* test/lcd_host_model.sv */
// Host processor model: AXI4-Lite master that paces instructions on the busy flag
module lcd_host_model (
	input wire logic clk_sys,
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
	end
	// =====================================================
	// Bus cycles
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, pa, pw, done;
		pa = 1'b1;
		pw = 1'b1;
		done = 1'b0;
		@(posedge clk_sys);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hf;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			// Ready seen at the falling edge holds until the next rising edge
			@(negedge clk_sys);
			ta = pa && awready;
			tw = pw && wready;
			done = !pa && !pw && bvalid;
			r = bresp;
			@(posedge clk_sys);
			if (ta) begin
				awvalid <= 1'b0;
				pa = 1'b0;
			end
			if (tw) begin
				wvalid <= 1'b0;
				pw = 1'b0;
			end
			if (done) begin
				bready <= 1'b0;
			end
		end
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, pa, done;
		pa = 1'b1;
		done = 1'b0;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(negedge clk_sys);
			ta = pa && arready;
			done = !pa && rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk_sys);
			if (ta) begin
				arvalid <= 1'b0;
				pa = 1'b0;
			end
			if (done) begin
				rready <= 1'b0;
			end
		end
	endtask : rd
	// =====================================================
	// Paced instruction traffic
	task automatic idle(output logic [31:0] s);
		logic [1:0] r;
		s = 32'h80;
		while (s[7] !== 1'b0) begin
			rd(8'h04, s, r);
		end
	endtask : idle
	task automatic instr(input logic [7:0] c);
		logic [31:0] s;
		logic [1:0] r;
		idle(s);
		wr(8'h00, {24'h0, c}, r);
	endtask : instr
	task automatic step();
		logic [31:0] s;
		logic [1:0] r;
		idle(s);
		wr(8'h0c, 32'h0, r);
	endtask : step
endmodule : lcd_host_model

/* test/lcd_basic_instruction_decoder_tb.sv */
// Self-checking testbench of the instruction decoder
module lcd_basic_instruction_decoder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic rst_n;
	logic [7:0] awaddr, araddr, fill_code;
	logic [31:0] wdata, rdata, v;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, clear_fill;
	logic [6:0] address_counter;
	logic busy_indicator, extended_group_select, bus_width_select, display_on, cursor_on;
	logic blink_on, entry_inc, entry_shift, scroll_or_ram_select, sleep_exit, graphic_on, standby;
	logic [3:0] reverse_lines;
	logic [7:0] shift_pos;
	wire [31:0] pin_mode = {8'h00, shift_pos, reverse_lines, 1'b0, standby, graphic_on, sleep_exit,
		scroll_or_ram_select, extended_group_select, bus_width_select, blink_on, cursor_on,
		display_on, entry_shift, entry_inc};
	int n_mismatch = 0;
	int checked = 0;
	int n_fill = 0;
	logic [7:0] sh_code [4] = '{8'h10, 8'h14, 8'h18, 8'h1c};
	logic [6:0] sh_ac [4] = '{7'h03, 7'h04, 7'h04, 7'h04};
	logic [31:0] sh_mode [4] = '{32'h126, 32'h126, 32'h10126, 32'h126};
	// Width before group, then extended reverse, scroll, sleep, standby, graphic, back to basic
	logic [7:0] fs_code [13] = '{8'h20, 8'h30, 8'h34, 8'h04, 8'h06, 8'h04, 8'h03, 8'h08, 8'h0c,
		8'h01, 8'h36, 8'h34, 8'h30};
	logic [31:0] fs_mode [13] = '{32'h105, 32'h125, 32'h165, 32'h1165, 32'h5165, 32'h4165,
		32'h41e5, 32'h40e5, 32'h41e5, 32'h45e5, 32'h43e5, 32'h41e5, 32'h41a5};
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (clear_fill === 1'b1) begin
			n_fill++;
		end
	end
	lcd_host_model host (.clk_sys(clk_sys), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	lcd_instr_decoder #(.CLEAR_CYC(20), .EXEC_CYC(4)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .busy_indicator(busy_indicator),
		.address_counter(address_counter), .extended_group_select(extended_group_select),
		.bus_width_select(bus_width_select), .display_on(display_on), .cursor_on(cursor_on),
		.blink_on(blink_on), .entry_inc(entry_inc), .entry_shift(entry_shift),
		.scroll_or_ram_select(scroll_or_ram_select), .sleep_exit(sleep_exit),
		.graphic_on(graphic_on), .standby(standby), .reverse_lines(reverse_lines),
		.shift_pos(shift_pos), .clear_fill(clear_fill),
		.fill_code(fill_code));
	// =====================================================
	// Checking helpers
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic mode_is(input logic [31:0] e);
		host.rd(8'h08, v, r);
		chk("mode", e, v);
		chk("mode pins", e, pin_mode);
	endtask : mode_is
	task automatic ac_is(input logic [6:0] e);
		host.idle(v);
		chk("counter", {25'h0, e}, v);
		chk("counter pin", {25'h0, e}, {25'h0, address_counter});
		chk("busy pin", 32'h0, {31'h0, busy_indicator});
	endtask : ac_is
	task automatic finish_test();
		if (n_mismatch == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : finish_test
	initial begin
		#200000;
		n_mismatch++;
		finish_test();
	end
	// =====================================================
	// Tests
	initial begin
		rst_n = 1'b0;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		mode_is(32'h121);
		ac_is(7'h00);
		host.instr(8'h0f);
		mode_is(32'h13d);
		host.instr(8'h0c);
		mode_is(32'h125);
		host.instr(8'h85);
		host.instr(8'h04);
		host.step();
		ac_is(7'h04);
		host.instr(8'h07);
		host.step();
		ac_is(7'h05);
		mode_is(32'h10127);
		host.instr(8'h05);
		host.step();
		ac_is(7'h04);
		mode_is(32'h126);
		foreach (sh_code[i]) begin
			host.instr(sh_code[i]);
			ac_is(sh_ac[i]);
			mode_is(sh_mode[i]);
		end
		host.instr(8'h85);
		host.instr(8'h18);
		host.instr(8'h03);
		ac_is(7'h00);
		mode_is(32'h126);
		host.instr(8'h04);
		host.instr(8'h85);
		host.instr(8'h01);
		// Display-off write lands inside the clear and must be dropped
		host.rd(8'h04, v, r);
		chk("busy", 32'h80, v & 32'h80);
		chk("busy pin", 32'h1, {31'h0, busy_indicator});
		host.wr(8'h00, 32'h08, r);
		host.rd(8'h10, v, r);
		chk("refused", 32'h1, v);
		ac_is(7'h00);
		mode_is(32'h125);
		chk("fills", 32'h1, 32'(n_fill));
		chk("fill code", 32'h20, {24'h0, fill_code});
		host.wr(8'h10, 32'h1, r);
		host.rd(8'h10, v, r);
		chk("refused", 32'h0, v);
		foreach (fs_code[i]) begin
			host.instr(fs_code[i]);
			mode_is(fs_mode[i]);
		end
		host.instr(8'h08);
		mode_is(32'h41a1);
		host.rd(8'h20, v, r);
		chk("read resp", 32'h2, {30'h0, r});
		chk("read data", 32'h0, v);
		host.wr(8'h20, 32'h1, r);
		chk("write resp", 32'h2, {30'h0, r});
		finish_test();
	end
endmodule : lcd_basic_instruction_decoder_tb
